/* File: nibble_cpu_defines.svh */
/*
  Constants of the nibble processor subset: opcode fields, sub-codes,
  condition bits and reset values.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef NIBBLE_CPU_DEFINES_SVH
`define NIBBLE_CPU_DEFINES_SVH

// Upper opcode nibbles
`define OPC_COND_JUMP    4'h1
`define OPC_PAIR_GROUP   4'h2
`define OPC_INC_SKIP     4'h7
`define OPC_ADD_REG      4'h8
`define OPC_SWAP_REG     4'hB
`define OPC_LOAD_IMM     4'hD
`define OPC_IO_GROUP     4'hE
`define OPC_ACC_GROUP    4'hF

// Lower nibbles inside the I/O and accumulator groups
`define SUB_WR_DATA_PORT 4'h1
`define SUB_RD_PROG_PORT 4'hA
`define SUB_INV_CARRY    4'h3
`define SUB_ROT_LEFT     4'h5
`define SUB_ROT_RIGHT    4'h6

// Condition field bit positions
`define COND_INVERT_BIT  3
`define COND_ACC_ZERO    2
`define COND_CARRY_BIT   1
`define COND_TEST_BIT    0

// Value an incrementing register holds just before it wraps
`define REG_WRAP_VALUE   4'hF

// Reset values
`define RST_ACC          4'h0
`define RST_CARRY        1'b0
`define RST_BYTE         8'h00

`endif

/* File: nibble_cpu_pkg.sv */
/*
  Types shared by the nibble processor subset.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package nibble_cpu_pkg;

  typedef enum logic [2:0]
  {
    ST_FETCH = 3'b001,
    ST_OPC   = 3'b010,
    ST_ARG   = 3'b100
  } cpu_state_e;

  typedef logic [3:0] nibble_t;
  typedef logic [7:0] byte_t;

endpackage

`default_nettype wire

/* File: index_reg_file.sv */
/*
  Sixteen 4-bit index registers, written singly or as even-odd pairs.
  Assumes writes come from the sequencer in the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module index_reg_file
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  input  wire logic                 we_single,
  input  wire nibble_cpu_pkg::nibble_t wr_idx,
  input  wire nibble_cpu_pkg::nibble_t wr_nib,
  input  wire logic                 we_pair,
  input  wire logic [2:0]           wr_pair,
  input  wire nibble_cpu_pkg::byte_t   wr_byte,
  input  wire nibble_cpu_pkg::nibble_t rd_idx,
  output var  nibble_cpu_pkg::nibble_t rd_nib,
  input  wire logic [2:0]           rd_pair,
  output var  nibble_cpu_pkg::byte_t   rd_byte
);
  import nibble_cpu_pkg::*;

  nibble_t regs [16];

  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_entry
      nibble_t val_reg;
      nibble_t val_next;
      always_comb
      begin
        val_next = val_reg;
        if (we_single && wr_idx == 4'(i))
          val_next = wr_nib;
        else if (we_pair && wr_pair == 3'(i >> 1))
          // Even register holds the high nibble of the pair
          val_next = (i % 2 == 0) ? wr_byte[7:4] : wr_byte[3:0];
      end
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          val_reg <= 4'h0;
        else if (ce)
          val_reg <= val_next;
      end
      assign regs[i] = val_reg;
    end
  endgenerate

  always_comb
  begin
    rd_nib  = regs[rd_idx];
    rd_byte = {regs[{rd_pair, 1'b0}], regs[{rd_pair, 1'b1}]};
  end

endmodule // index_reg_file

`default_nettype wire

/* File: jump_cond_eval.sv */
/*
  Evaluates the condition field of the conditional jump.
  Assumes the test input is already synchronous to the core clock.
*/
`timescale 1ns/10ps
`include "nibble_cpu_defines.svh"
`default_nettype none

module jump_cond_eval
(
  input  wire logic                    cond_en,
  input  wire nibble_cpu_pkg::nibble_t cond,
  input  wire nibble_cpu_pkg::nibble_t acc,
  input  wire logic                    carry,
  input  wire logic                    test_pin,
  output var  logic                    take_jump
);
  import nibble_cpu_pkg::*;

  logic raw;

  always_comb
  begin
    raw = (cond[`COND_ACC_ZERO] && acc == 4'h0)
        | (cond[`COND_CARRY_BIT] && carry)
        | (cond[`COND_TEST_BIT] && !test_pin);
    // Invert bit flips the whole test
    take_jump = cond_en && (raw ^ cond[`COND_INVERT_BIT]);
  end

endmodule // jump_cond_eval

`default_nettype wire

/* File: nibble_cpu_core.sv */
/*
  Execution core for a subset of a 4-bit processor: conditional jump,
  chip select, port read and write, immediate loads, swap and add with
  index registers, rotation through carry and increment-and-skip.
  Assumes program memory answers rom_data in the same clock that rom_addr
  changes, and that prog_port_in shows the port of the program-memory
  chip named on prog_chip_sel. All inputs are synchronous to clk.
*/
`timescale 1ns/10ps
`include "nibble_cpu_defines.svh"
`default_nettype none

// Overview of operation
// - Conditional jump is two words: condition opcode, then low target.
// - Condition 0001 jumps only when the test pin is low.
// - Taken jump loads target; otherwise continue after second word.
// - Top condition bit inverts the test; 1001 jumps on test high.
// - Read program port loads accumulator from last selected chip port.
// - Chip select sends a pair; high nibble names program chip.
// - Top two bits of that nibble name the data-memory chip.
// - Fetch immediate loads the second word into a register pair.
// - Opcode 1101 copies its low nibble into the accumulator.
// - Add and swap use the named register contents as operand.
// - Swap exchanges accumulator and the named register.
// - Increment-skip adds one; jumps unless old value was 1111.
// - Increment-skip target stays on the page after the instruction.
// - Increment-skip leaves the accumulator unchanged.
// - Write data port sends accumulator to last selected data chip.
// - Rotates go through carry; invert carry complements it.
// - Accumulator bit 0 drives port line 0; value holds until rewritten.
module nibble_cpu_core
#(
  parameter int PC_W = 12
)
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  input  wire logic                    test_pin,
  input  wire nibble_cpu_pkg::byte_t   rom_data,
  input  wire nibble_cpu_pkg::nibble_t prog_port_in,
  output var  logic [PC_W-1:0]         rom_addr,
  output var  nibble_cpu_pkg::nibble_t acc_out,
  output var  logic                    carry_out,
  output var  nibble_cpu_pkg::byte_t   chip_sel_addr,
  output var  nibble_cpu_pkg::nibble_t prog_chip_sel,
  output var  logic [1:0]              data_chip_sel,
  output var  logic                    chip_sel_strobe,
  output var  nibble_cpu_pkg::nibble_t data_port_val,
  output var  logic                    data_port_wr
);
  import nibble_cpu_pkg::*;

  generate
    if (PC_W < 9)
    begin : g_bad_width
      $error("PC_W must leave a page field above the 8-bit low address");
    end
  endgenerate

  cpu_state_e      state_reg,   state_next;
  logic [PC_W-1:0] pc_reg,      pc_next;
  logic [PC_W-1:0] addr_reg,    addr_next;
  byte_t           opc_reg,     opc_next;
  nibble_t         acc_reg,     acc_next;
  logic            carry_reg,   carry_next;
  byte_t           sel_reg,     sel_next;
  nibble_t         pchip_reg,   pchip_next;
  logic [1:0]      dchip_reg,   dchip_next;
  logic            sel_stb_reg, sel_stb_next;
  nibble_t         dport_reg,   dport_next;
  logic            dwr_reg,     dwr_next;

  byte_t   cur;
  logic    two_word;
  logic    we_single;
  nibble_t wr_nib;
  logic    we_pair;
  nibble_t rf_nib;
  byte_t   rf_byte;
  logic    jcn_take;
  logic [4:0] sum;

  // Opcode in execution: fresh word in ST_OPC, held word in ST_ARG
  always_comb
  begin
    cur = (state_reg == ST_ARG) ? opc_reg : rom_data;
  end

  index_reg_file u_regs
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .we_single (we_single),
    .wr_idx    (cur[3:0]),
    .wr_nib    (wr_nib),
    .we_pair   (we_pair),
    .wr_pair   (cur[3:1]),
    .wr_byte   (rom_data),
    .rd_idx    (cur[3:0]),
    .rd_nib    (rf_nib),
    .rd_pair   (cur[3:1]),
    .rd_byte   (rf_byte)
  );

  jump_cond_eval u_cond
  (
    .cond_en   (state_reg == ST_ARG && cur[7:4] == `OPC_COND_JUMP),
    .cond      (cur[3:0]),
    .acc       (acc_reg),
    .carry     (carry_reg),
    .test_pin  (test_pin),
    .take_jump (jcn_take)
  );

  always_comb
  begin
    two_word = (cur[7:4] == `OPC_COND_JUMP)
             || (cur[7:4] == `OPC_INC_SKIP)
             || (cur[7:4] == `OPC_PAIR_GROUP && !cur[0]);
    sum      = {1'b0, acc_reg} + {1'b0, rf_nib} + {4'h0, carry_reg};
  end

  always_comb
  begin
    state_next   = state_reg;
    pc_next      = pc_reg;
    addr_next    = addr_reg;
    opc_next     = opc_reg;
    acc_next     = acc_reg;
    carry_next   = carry_reg;
    sel_next     = sel_reg;
    pchip_next   = pchip_reg;
    dchip_next   = dchip_reg;
    sel_stb_next = 1'b0;
    dport_next   = dport_reg;
    dwr_next     = 1'b0;
    we_single    = 1'b0;
    wr_nib       = rf_nib;
    we_pair      = 1'b0;
    case (state_reg)
      ST_FETCH:
      begin
        addr_next  = pc_reg;
        pc_next    = pc_reg + 1'b1;
        state_next = ST_OPC;
      end
      ST_OPC:
      begin
        opc_next   = rom_data;
        state_next = ST_FETCH;
        if (two_word)
        begin
          addr_next  = pc_reg;
          pc_next    = pc_reg + 1'b1;
          state_next = ST_ARG;
        end
        else
        begin
          case (cur[7:4])
            `OPC_PAIR_GROUP:
            begin
              sel_next     = rf_byte;
              pchip_next   = rf_byte[7:4];
              dchip_next   = rf_byte[7:6];
              sel_stb_next = 1'b1;
            end
            `OPC_ADD_REG:
            begin
              acc_next   = sum[3:0];
              carry_next = sum[4];
            end
            `OPC_SWAP_REG:
            begin
              acc_next  = rf_nib;
              we_single = 1'b1;
              wr_nib    = acc_reg;
            end
            `OPC_LOAD_IMM:
              acc_next = cur[3:0];
            `OPC_IO_GROUP:
            begin
              if (cur[3:0] == `SUB_WR_DATA_PORT)
              begin
                dport_next = acc_reg;
                dwr_next   = 1'b1;
              end
              else if (cur[3:0] == `SUB_RD_PROG_PORT)
                acc_next = prog_port_in;
            end
            `OPC_ACC_GROUP:
            begin
              case (cur[3:0])
                `SUB_INV_CARRY:
                  carry_next = !carry_reg;
                `SUB_ROT_LEFT:
                begin
                  acc_next   = {acc_reg[2:0], carry_reg};
                  carry_next = acc_reg[3];
                end
                `SUB_ROT_RIGHT:
                begin
                  acc_next   = {carry_reg, acc_reg[3:1]};
                  carry_next = acc_reg[0];
                end
                default:
                  acc_next = acc_reg;
              endcase
            end
            default:
              acc_next = acc_reg;
          endcase
        end
      end
      ST_ARG:
      begin
        state_next = ST_FETCH;
        case (cur[7:4])
          `OPC_COND_JUMP:
            if (jcn_take)
              pc_next = {pc_reg[PC_W-1:8], rom_data};
          `OPC_INC_SKIP:
          begin
            we_single = 1'b1;
            wr_nib    = rf_nib + 4'h1;
            if (rf_nib != `REG_WRAP_VALUE)
              pc_next = {pc_reg[PC_W-1:8], rom_data};
          end
          `OPC_PAIR_GROUP:
            we_pair = 1'b1;
          default:
            pc_next = pc_reg;
        endcase
      end
      default:
        state_next = ST_FETCH;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg   <= ST_FETCH;
      pc_reg      <= '0;
      addr_reg    <= '0;
      opc_reg     <= `RST_BYTE;
      acc_reg     <= `RST_ACC;
      carry_reg   <= `RST_CARRY;
      sel_reg     <= `RST_BYTE;
      pchip_reg   <= 4'h0;
      dchip_reg   <= 2'h0;
      sel_stb_reg <= 1'b0;
      dport_reg   <= 4'h0;
      dwr_reg     <= 1'b0;
    end
    else if (ce)
    begin
      state_reg   <= state_next;
      pc_reg      <= pc_next;
      addr_reg    <= addr_next;
      opc_reg     <= opc_next;
      acc_reg     <= acc_next;
      carry_reg   <= carry_next;
      sel_reg     <= sel_next;
      pchip_reg   <= pchip_next;
      dchip_reg   <= dchip_next;
      sel_stb_reg <= sel_stb_next;
      dport_reg   <= dport_next;
      dwr_reg     <= dwr_next;
    end
  end

  assign rom_addr        = addr_reg;
  assign acc_out         = acc_reg;
  assign carry_out       = carry_reg;
  assign chip_sel_addr   = sel_reg;
  assign prog_chip_sel   = pchip_reg;
  assign data_chip_sel   = dchip_reg;
  assign chip_sel_strobe = sel_stb_reg;
  assign data_port_val   = dport_reg;
  assign data_port_wr    = dwr_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic at_opc;
  logic at_arg;
  assign at_opc = ce && state_reg == ST_OPC;
  assign at_arg = ce && state_reg == ST_ARG;

  a_jcn_test_low: assert property (
    at_arg && opc_reg == 8'h11 && !test_pin
    |=> pc_reg == {$past(pc_reg[PC_W-1:8]), $past(rom_data)})
    else $error("jump on low test not taken");
  a_jcn_invert: assert property (
    at_arg && opc_reg == 8'h19 && !test_pin |=> pc_reg == $past(pc_reg))
    else $error("inverted jump taken on low test");
  a_ldm_load: assert property (
    at_opc && rom_data[7:4] == `OPC_LOAD_IMM
    |=> acc_reg == $past(rom_data[3:0]))
    else $error("load immediate value wrong");
  a_swap_acc: assert property (
    at_opc && rom_data[7:4] == `OPC_SWAP_REG
    |=> acc_reg == $past(rf_nib) && rf_nib == $past(acc_reg))
    else $error("swap did not exchange");
  a_isz_acc_keep: assert property (
    at_arg && opc_reg[7:4] == `OPC_INC_SKIP |=> $stable(acc_reg))
    else $error("increment-skip changed accumulator");
  a_isz_wrap: assert property (
    at_arg && opc_reg[7:4] == `OPC_INC_SKIP && rf_nib == 4'hF
    |-> we_single && wr_nib == 4'h0 ##1 pc_reg == $past(pc_reg))
    else $error("increment-skip wrap wrong");
  a_rot_left: assert property (
    at_opc && rom_data == 8'hF5
    |=> {carry_reg, acc_reg} == {$past(acc_reg), $past(carry_reg)})
    else $error("rotate left wrong");
  a_sel_chips: assert property (
    at_opc && rom_data[7:4] == `OPC_PAIR_GROUP && rom_data[0]
    |=> chip_sel_strobe && chip_sel_addr == $past(rf_byte)
        && prog_chip_sel == $past(rf_byte[7:4])
        && data_chip_sel == $past(rf_byte[7:6]))
    else $error("chip select decode wrong");
  a_port_hold: assert property (
    !data_port_wr |-> ##1 (data_port_wr || $stable(data_port_val)))
    else $error("data port changed without write");
  a_port_write: assert property (
    at_opc && rom_data == 8'hE1 |=> data_port_wr
      && data_port_val == $past(acc_reg))
    else $error("port write value wrong");
  c_jump_taken: cover property (at_arg && jcn_take);
  c_isz_loop: cover property (at_arg && opc_reg[7:4] == `OPC_INC_SKIP
    && rf_nib != 4'hF);
  c_chip_sel: cover property (chip_sel_strobe ##[1:20] data_port_wr);
  c_rdr: cover property (at_opc && rom_data == 8'hEA);

endmodule // nibble_cpu_core

`default_nettype wire

/* File: nibble_mem_model.sv */
/*
  Far-side model: program memory with a load port, program-memory chip
  input ports and data-memory chip output ports, with one write counter and a chip-select counter.
  Assumes the core drives it on the rising edge of clk.
*/
`timescale 1ns/10ps
`default_nettype none

module nibble_mem_model
#(
  parameter int PC_W = 12
)
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ld_clr,
  input  wire logic                    ld_we,
  input  wire logic [8:0]              ld_addr,
  input  wire nibble_cpu_pkg::byte_t   ld_data,
  input  wire logic [PC_W-1:0]         rom_addr,
  output var  nibble_cpu_pkg::byte_t   rom_data,
  input  wire nibble_cpu_pkg::nibble_t prog_chip_sel,
  output var  nibble_cpu_pkg::nibble_t prog_port_in,
  input  wire logic [1:0]              data_chip_sel,
  input  wire nibble_cpu_pkg::nibble_t data_port_val,
  input  wire logic                    data_port_wr,
  input  wire logic                    chip_sel_strobe,
  output var  logic [3:0][3:0]         dport,
  output var  logic [7:0]              wr_cnt,
  output var  logic [7:0]              sel_cnt
);
  import nibble_cpu_pkg::*;

  byte_t mem [512];

  always_ff @(posedge clk)
  begin
    if (ld_clr)
      mem <= '{default: 8'h00};
    else if (ld_we)
      mem[ld_addr] <= ld_data;
  end

  assign rom_data = mem[rom_addr[8:0]];
  // Each chip's input port shows its own number with a fixed twist
  assign prog_port_in = prog_chip_sel ^ 4'h6;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dport   <= '0;
      wr_cnt  <= 8'h00;
      sel_cnt <= 8'h00;
    end
    else
    begin
      // Chip keeps its value until written again
      if (data_port_wr)
      begin
        dport[data_chip_sel] <= data_port_val;
        wr_cnt <= wr_cnt + 8'h01;
      end
      if (chip_sel_strobe)
        sel_cnt <= sel_cnt + 8'h01;
    end
  end
endmodule // nibble_mem_model

`default_nettype wire

/* File: cpu_branch_loop_io_subset_tb_top.sv */
/*
  Self-checking bench: small programs run from the memory model.
  Assumes nibble_cpu_core and nibble_mem_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module cpu_branch_loop_io_subset_tb_top;
  import nibble_cpu_pkg::*;
  localparam int PC_W = 12;

  logic            clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            ce = 1'b1;
  logic            test_pin = 1'b0;
  logic            ld_clr = 1'b0;
  logic            ld_we = 1'b0;
  logic [8:0]      ld_addr = 9'h000;
  byte_t           ld_data = 8'h00;
  byte_t           rom_data;
  nibble_t         prog_port_in;
  logic [PC_W-1:0] rom_addr;
  nibble_t         acc_out;
  logic            carry_out;
  byte_t           chip_sel_addr;
  nibble_t         prog_chip_sel;
  logic [1:0]      data_chip_sel;
  logic            chip_sel_strobe;
  nibble_t         data_port_val;
  logic            data_port_wr;
  logic [3:0][3:0] dport;
  logic [7:0]      wr_cnt;
  logic [7:0]      sel_cnt;
  int              n_mismatch = 0;
  int              checks_done = 0;
  byte_t           prog [$];

  always #12.5 clk = ~clk;

  nibble_cpu_core #(.PC_W(PC_W)) dut_u
  (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .test_pin(test_pin),
    .rom_data(rom_data), .prog_port_in(prog_port_in),
    .rom_addr(rom_addr), .acc_out(acc_out), .carry_out(carry_out),
    .chip_sel_addr(chip_sel_addr), .prog_chip_sel(prog_chip_sel),
    .data_chip_sel(data_chip_sel), .chip_sel_strobe(chip_sel_strobe),
    .data_port_val(data_port_val), .data_port_wr(data_port_wr)
  );

  nibble_mem_model #(.PC_W(PC_W)) mem_u
  (
    .clk(clk), .sys_rst(sys_rst), .ld_clr(ld_clr), .ld_we(ld_we),
    .ld_addr(ld_addr), .ld_data(ld_data), .rom_addr(rom_addr),
    .rom_data(rom_data), .prog_chip_sel(prog_chip_sel),
    .prog_port_in(prog_port_in), .data_chip_sel(data_chip_sel),
    .data_port_val(data_port_val), .data_port_wr(data_port_wr),
    .chip_sel_strobe(chip_sel_strobe), .dport(dport),
    .wr_cnt(wr_cnt), .sel_cnt(sel_cnt)
  );

  task automatic test_done;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // Writes prog at base, optionally clearing memory first
  task automatic load(input logic [8:0] base, input logic clr);
    int k;
    begin
      if (clr)
      begin
        @(posedge clk) ld_clr <= 1'b1;
        @(posedge clk) ld_clr <= 1'b0;
      end
      for (k = 0; k < prog.size(); k++)
      begin
        @(posedge clk);
        ld_we   <= 1'b1;
        ld_addr <= base + 9'(k);
        ld_data <= prog[k];
      end
      @(posedge clk) ld_we <= 1'b0;
    end
  endtask

  // Resets the core and runs until the stop address is fetched
  task automatic run(input logic [8:0] stop);
    int i;
    begin
      @(posedge clk) sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      i = 0;
      @(negedge clk);
      while (rom_addr[8:0] !== stop && i < 600)
      begin
        @(negedge clk);
        i++;
      end
      check("stop reached", 12'(i < 600), 12'h001);
      repeat (4) @(negedge clk);
    end
  endtask

  task automatic s_cond_jump;
    nibble_t cond;
    logic    take;
    int      j;
    begin
      for (j = 0; j < 4; j++)
      begin
        cond = j[1] ? 4'h9 : 4'h1;
        take = cond[3] ^ ~j[0];
        prog = '{{4'h1, cond}, 8'h10, 8'hD5, 8'h18, 8'h20};
        load(9'h000, 1'b1);
        prog = '{8'hDA, 8'h18, 8'h20};
        load(9'h010, 1'b0);
        @(posedge clk) test_pin <= j[0];
        run(9'h020);
        check("jump acc", 12'(acc_out), take ? 12'h00A : 12'h005);
      end
    end
  endtask

  task automatic s_chip_sel;
    begin
      prog = '{8'h20, 8'h20, 8'h21, 8'hEA, 8'hB5, 8'h26, 8'hC7, 8'h27,
               8'hEA, 8'hB6, 8'hB5, 8'hE1, 8'hB6, 8'h21, 8'hE1};
      load(9'h000, 1'b1);
      run(9'h00F);
      check("read port acc", 12'(acc_out), 12'h00A);
      check("chip 3 port", 12'(dport[3]), 12'h004);
      check("chip 0 port", 12'(dport[0]), 12'h00A);
      check("sel addr", 12'(chip_sel_addr), 12'h020);
      check("prog chip", 12'(prog_chip_sel), 12'h002);
      check("data chip", 12'(data_chip_sel), 12'h000);
      check("sel count", 12'(sel_cnt), 12'h003);
    end
  endtask

  task automatic s_add_swap;
    begin
      prog = '{8'hD8, 8'hBF, 8'hD3, 8'h88, 8'h8F};
      load(9'h000, 1'b1);
      run(9'h005);
      check("add acc", 12'(acc_out), 12'h00B);
      check("add carry", 12'(carry_out), 12'h000);
    end
  endtask

  task automatic s_loop;
    nibble_t a;
    logic    c;
    int      j;
    begin
      a = 4'h0;
      c = 1'b0;
      for (j = 0; j < 20; j++)
        {c, a} = 5'(a) + 5'h08 + 5'(c);
      prog = '{8'hD8, 8'hBF, 8'hD6, 8'hBE, 8'h20, 8'hC0, 8'h21, 8'hD0,
               8'h8F, 8'hE1, 8'h8F, 8'hE1, 8'h7E, 8'h08, 8'hE1, 8'hBE};
      load(9'h000, 1'b1);
      run(9'h010);
      check("loop writes", 12'(wr_cnt), 12'h015);
      check("loop port", 12'(dport[3]), 12'(a));
      check("wrapped reg", 12'(acc_out), 12'h000);
    end
  endtask

  task automatic s_page;
    begin
      prog = '{8'h18, 8'hFE};
      load(9'h000, 1'b1);
      prog = '{8'h70, 8'h40};
      load(9'h0FE, 1'b0);
      prog = '{8'hD1, 8'h18, 8'h41};
      load(9'h040, 1'b0);
      prog = '{8'h18, 8'h00};
      load(9'h100, 1'b0);
      prog = '{8'hD9};
      load(9'h140, 1'b0);
      run(9'h141);
      check("page acc", 12'(acc_out), 12'h009);
    end
  endtask

  task automatic s_rotate;
    begin
      prog = '{8'hD9, 8'hF5, 8'hF3, 8'hF6, 8'hF3, 8'hF6};
      load(9'h000, 1'b1);
      run(9'h006);
      check("rot acc", 12'(acc_out), 12'h008);
      check("rot carry", 12'(carry_out), 12'h001);
    end
  endtask

  // Clock enable low must freeze the running core
  task automatic s_freeze;
    logic [11:0] held;
    begin
      @(posedge clk) ce <= 1'b0;
      @(negedge clk) held = 12'(rom_addr);
      repeat (6) @(negedge clk);
      check("frozen addr", 12'(rom_addr), held);
      check("frozen acc", 12'(acc_out), 12'h008);
      @(posedge clk) ce <= 1'b1;
      repeat (4) @(negedge clk);
      check("running addr", 12'(rom_addr != held), 12'h001);
    end
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    s_cond_jump();
    s_chip_sel();
    s_add_swap();
    s_loop();
    s_page();
    s_rotate();
    s_freeze();
    test_done();
  end

  initial
  begin
    #1000000;
    n_mismatch++;
    test_done();
  end
endmodule // cpu_branch_loop_io_subset_tb_top

`default_nettype wire
